// File: adc_readout_pkg.sv
package adc_readout_pkg;

   // Result word layout
   localparam int WORD_BITS = 24;
   localparam int CODE_BITS = 22;
   localparam int FILTER_BITS = 23;
   localparam int OVERRANGE_LOW_BIT = 23;
   localparam int OVERRANGE_HIGH_BIT = 22;
   localparam int SIGN_BIT = 21;
   localparam int MAGNITUDE_MSB = 20;

   // Code limits inside the nominal range, in filter width
   localparam logic [FILTER_BITS-1:0] POS_FULL_CODE = 23'h1f_ffff;
   localparam logic [FILTER_BITS-1:0] NEG_FULL_CODE = 23'h60_0000;

   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int POWERUP_CYCLES = 32;
   localparam longint CONVERSION_TIME_US_X10 = 727;
   localparam longint CONVERSION_CYCLES_LONG =
      (CONVERSION_TIME_US_X10 * 64'h0000_0000_05f5_e100) / CLK_PERIOD_PS;
   localparam int unsigned CONVERSION_CYCLES_DEFAULT = int'(CONVERSION_CYCLES_LONG);
   localparam int CYCLE_COUNT_BITS = 32;

   // Serial frame counts
   localparam int BIT_COUNT_BITS = 5;
   localparam logic [BIT_COUNT_BITS-1:0] BIT_COUNT_IDLE = 5'h00;
   localparam logic [BIT_COUNT_BITS-1:0] BIT_COUNT_FIRST = 5'h01;
   localparam logic [BIT_COUNT_BITS-1:0] BIT_COUNT_LAST = 5'h18;

   // Values after reset
   localparam logic [WORD_BITS-1:0] WORD_RESET = 24'h00_0000;
   localparam logic [CYCLE_COUNT_BITS-1:0] COUNT_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_SHUTDOWN = 2'b00,
      ST_POWERUP = 2'b01,
      ST_CONVERT = 2'b11,
      ST_SLEEP = 2'b10
   } conv_state_t;

endpackage

// File: readout_link_if.sv
`timescale 1ns/10ps
interface readout_link_if;
   import adc_readout_pkg::*;

   logic [WORD_BITS-1:0] word;
   logic avail;
   logic taken_toggle;
   logic done_toggle;
   logic shifting;
   logic bit_out;

   modport control (
      output word,
      output avail,
      input taken_toggle,
      input done_toggle,
      input shifting,
      input bit_out
   );

   modport shifter (
      input word,
      input avail,
      output taken_toggle,
      output done_toggle,
      output shifting,
      output bit_out
   );

endinterface

// File: readout_shifter.sv
`timescale 1ns/10ps
module readout_shifter
   import adc_readout_pkg::*;
(
   input wire logic sck,
   input wire logic cs_n,
   input wire logic reset,
   readout_link_if.shifter link
);

   logic [BIT_COUNT_BITS-1:0] count_reg;
   logic [WORD_BITS-1:0] shift_reg;
   logic shifting_reg;
   logic bit_reg;
   logic taken_reg;
   logic done_reg;

   wire idle = (count_reg == BIT_COUNT_IDLE);
   wire load = idle & link.avail;
   wire last = (count_reg == BIT_COUNT_LAST);

   // Frame state, cleared whenever chip select goes high
   always_ff @(negedge sck or posedge cs_n or posedge reset) begin
      if (reset || cs_n) begin
         count_reg <= BIT_COUNT_IDLE;
         shift_reg <= WORD_RESET;
         shifting_reg <= 1'b0;
         bit_reg <= 1'b0;
      end else if (load) begin
         count_reg <= BIT_COUNT_FIRST; // [RULE_01]
         shift_reg <= link.word;
         shifting_reg <= 1'b1;
         bit_reg <= link.word[WORD_BITS-1]; // [RULE_09]
      end else if (last) begin
         count_reg <= BIT_COUNT_IDLE; // [RULE_21]
         shifting_reg <= 1'b0;
      end else if (!idle) begin
         count_reg <= count_reg + BIT_COUNT_FIRST;
         shift_reg <= {shift_reg[WORD_BITS-2:0], 1'b0};
         bit_reg <= shift_reg[WORD_BITS-2]; // [RULE_09]
      end
   end

   // Events toward the control domain
   always_ff @(negedge sck or posedge reset) begin
      if (reset) begin
         taken_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         if (load && !cs_n) begin
            taken_reg <= ~taken_reg;
         end
         if (last && !cs_n) begin
            done_reg <= ~done_reg; // [RULE_20]
         end
      end
   end

   assign link.shifting = shifting_reg;
   assign link.bit_out = bit_reg;
   assign link.taken_toggle = taken_reg;
   assign link.done_toggle = done_reg;

endmodule

// File: adc_serial_readout_control.sv
`timescale 1ns/10ps
// How it works
// RULE_01: Each result is 24 bits: 22 code bits and two overrange flags.
// RULE_02: With chip select low, pin is high while busy, low once data ready.
// RULE_03: Pin stays undriven while chip select is high.
// RULE_04: Host keeps chip select low throughout any clocking out of data.
// RULE_05: Overrange high flag, bit 22, set above reference minus one step.
// RULE_06: Overrange low flag, bit 23, set below negative reference.
// RULE_07: Host treats both flags set as a communication error.
// RULE_08: Bits 21 to 0 are two's complement, bit 21 the sign.
// RULE_09: Code bits go out most significant first.
// RULE_10: Both flags clear while input is within nominal range.
// RULE_11: Code keeps counting past full scale, no saturation.
// RULE_12: On overrange, low flag acts as sign of a 23-bit code.
// RULE_13: Chip select falling in shutdown starts a conversion.
// RULE_14: Result is complete at end of fixed conversion time, no latency.
// RULE_15: Single mode stores result and starts nothing more.
// RULE_16: Continuous mode restarts on its own; output holds newest result.
// RULE_17: Leaving shutdown waits a power-up delay before converting.
// RULE_18: Power-up delay is 32 oscillator periods.
// RULE_19: Chip select rising during conversion selects single mode.
// RULE_20: Output buffer is not refreshed while a 24-bit read is under way.
// RULE_21: Host with idle-low clock reads ready bit then 24 data bits.
module adc_serial_readout_control
   import adc_readout_pkg::*;
#(
   parameter int unsigned CONVERSION_CYCLES = CONVERSION_CYCLES_DEFAULT
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic sck,
   input wire logic cs_n_pin,
   input wire logic [FILTER_BITS-1:0] filter_code,
   output logic data_out_ready_pin_out,
   output logic data_out_ready_pin_oe_n,
   output logic modulator_run,
   output logic modulator_start,
   output logic single_mode,
   output logic shutdown
);

   readout_link_if link ();

   readout_shifter shifter_inst (
      .sck(sck),
      .cs_n(cs_n_pin),
      .reset(reset),
      .link(link.shifter)
   );

   localparam logic [CYCLE_COUNT_BITS-1:0] POWERUP_LAST =
      CYCLE_COUNT_BITS'(POWERUP_CYCLES - 1);
   localparam logic [CYCLE_COUNT_BITS-1:0] CONVERT_LAST =
      CYCLE_COUNT_BITS'(CONVERSION_CYCLES - 1);
   localparam logic [CYCLE_COUNT_BITS-1:0] COUNT_STEP = 32'h0000_0001;

   // Chip select synchroniser and edge history
   logic cs_meta_reg;
   logic cs_sync_reg;
   logic cs_prev_reg;

   // Event synchronisers from the serial clock domain
   logic taken_meta_reg;
   logic taken_sync_reg;
   logic taken_seen_reg;
   logic done_meta_reg;
   logic done_sync_reg;
   logic done_seen_reg;

   // Conversion control
   conv_state_t state_reg;
   conv_state_t state_next;
   logic [CYCLE_COUNT_BITS-1:0] count_reg;
   logic [CYCLE_COUNT_BITS-1:0] count_next;
   logic single_reg;
   logic single_next;

   // Output buffer
   logic [WORD_BITS-1:0] word_reg;
   logic [WORD_BITS-1:0] word_next;
   logic [WORD_BITS-1:0] pending_reg;
   logic [WORD_BITS-1:0] pending_next;
   logic pending_valid_reg;
   logic pending_valid_next;
   logic avail_reg;
   logic avail_next;
   logic frame_busy_reg;
   logic frame_busy_next;

   // Registered outputs
   logic ready_pin_reg;
   logic oe_n_reg;
   logic run_reg;
   logic start_reg;
   logic shutdown_reg;

   // Edge and event decode
   wire cs_low = ~cs_sync_reg;
   wire cs_rise = cs_sync_reg & ~cs_prev_reg;
   wire taken_evt = taken_sync_reg ^ taken_seen_reg;
   wire done_evt = done_sync_reg ^ done_seen_reg;

   wire powerup_done = (state_reg == ST_POWERUP) && (count_reg == POWERUP_LAST);
   wire conv_done = (state_reg == ST_CONVERT) && (count_reg == CONVERT_LAST);
   wire conv_begin = (state_next == ST_CONVERT) && ((state_reg != ST_CONVERT) || conv_done);
   wire enter_shutdown = (state_next == ST_SHUTDOWN) && (state_reg != ST_SHUTDOWN);

   // Result encoding from the filter code
   wire over_high = $signed(filter_code) > $signed(POS_FULL_CODE); // [RULE_05]
   wire over_low = $signed(filter_code) < $signed(NEG_FULL_CODE); // [RULE_06]
   wire [CODE_BITS-1:0] code_bits = filter_code[CODE_BITS-1:0]; // [RULE_08] [RULE_11]
   wire [WORD_BITS-1:0] result_word = {over_low, over_high, code_bits}; // [RULE_10] [RULE_12]

   // Buffer update decode
   wire lose_data = enter_shutdown | cs_rise;
   wire publish_new = conv_done & (~frame_busy_reg | done_evt); // [RULE_14]
   wire hold_new = conv_done & frame_busy_reg & ~done_evt; // [RULE_20]
   wire publish_pending = done_evt & pending_valid_reg & ~conv_done;

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else begin
         cs_meta_reg <= cs_n_pin;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         taken_meta_reg <= 1'b0;
         taken_sync_reg <= 1'b0;
         taken_seen_reg <= 1'b0;
         done_meta_reg <= 1'b0;
         done_sync_reg <= 1'b0;
         done_seen_reg <= 1'b0;
      end else begin
         taken_meta_reg <= link.taken_toggle;
         taken_sync_reg <= taken_meta_reg;
         taken_seen_reg <= taken_sync_reg;
         done_meta_reg <= link.done_toggle;
         done_sync_reg <= done_meta_reg;
         done_seen_reg <= done_sync_reg;
      end
   end

   // Conversion sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_SHUTDOWN: begin
            if (cs_low) begin
               state_next = ST_POWERUP; // [RULE_13]
            end
         end
         ST_POWERUP: begin
            if (powerup_done) begin
               state_next = ST_CONVERT; // [RULE_17] [RULE_18]
            end
         end
         ST_CONVERT: begin
            if (conv_done) begin
               if (single_reg || cs_rise) begin
                  state_next = cs_sync_reg ? ST_SHUTDOWN : ST_SLEEP; // [RULE_15]
               end else begin
                  state_next = ST_CONVERT; // [RULE_16]
               end
            end
         end
         ST_SLEEP: begin
            if (cs_rise) begin
               state_next = ST_SHUTDOWN;
            end
         end
         default: begin
            state_next = ST_SHUTDOWN;
         end
      endcase
   end

   always_comb begin
      if (conv_done || (state_next != state_reg)) begin
         count_next = COUNT_RESET;
      end else if ((state_reg == ST_POWERUP) || (state_reg == ST_CONVERT)) begin
         count_next = count_reg + COUNT_STEP; // [RULE_18]
      end else begin
         count_next = COUNT_RESET;
      end
   end

   always_comb begin
      if (conv_begin) begin
         single_next = cs_rise; // [RULE_19]
      end else if ((state_reg == ST_CONVERT) && cs_rise) begin
         single_next = 1'b1; // [RULE_19]
      end else if (state_next == ST_SHUTDOWN) begin
         single_next = 1'b0;
      end else begin
         single_next = single_reg;
      end
   end

   // Output buffer and handshake with the serial side
   always_comb begin
      word_next = word_reg;
      if (publish_new) begin
         word_next = result_word; // [RULE_16]
      end else if (publish_pending) begin
         word_next = pending_reg; // [RULE_20]
      end
   end

   always_comb begin
      pending_next = pending_reg;
      pending_valid_next = pending_valid_reg;
      if (hold_new) begin
         pending_next = result_word; // [RULE_20]
         pending_valid_next = 1'b1;
      end else if (done_evt || lose_data) begin
         pending_valid_next = 1'b0;
      end
   end

   always_comb begin
      avail_next = avail_reg;
      if (lose_data) begin
         avail_next = 1'b0;
      end else if (publish_new || publish_pending) begin
         avail_next = 1'b1; // [RULE_02]
      end else if (taken_evt) begin
         avail_next = 1'b0;
      end
   end

   always_comb begin
      frame_busy_next = frame_busy_reg;
      if (taken_evt) begin
         frame_busy_next = 1'b1; // [RULE_20]
      end else if (done_evt || cs_rise) begin
         frame_busy_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= ST_SHUTDOWN;
         count_reg <= COUNT_RESET;
         single_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         single_reg <= single_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         word_reg <= WORD_RESET;
         pending_reg <= WORD_RESET;
         pending_valid_reg <= 1'b0;
         avail_reg <= 1'b0;
         frame_busy_reg <= 1'b0;
      end else begin
         word_reg <= word_next;
         pending_reg <= pending_next;
         pending_valid_reg <= pending_valid_next;
         avail_reg <= avail_next;
         frame_busy_reg <= frame_busy_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ready_pin_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         run_reg <= 1'b0;
         start_reg <= 1'b0;
         shutdown_reg <= 1'b1;
      end else begin
         ready_pin_reg <= ~avail_next; // [RULE_02]
         oe_n_reg <= cs_sync_reg; // [RULE_03]
         run_reg <= (state_next == ST_CONVERT); // [RULE_13]
         start_reg <= conv_begin;
         shutdown_reg <= (state_next == ST_SHUTDOWN);
      end
   end

   // Host keeps chip select low for the frame, so word and avail are stable at load
   assign link.word = word_reg; // [RULE_04]
   assign link.avail = avail_reg;

   // Data bit during a frame, ready state otherwise
   assign data_out_ready_pin_out = link.shifting ? link.bit_out : ready_pin_reg; // [RULE_02]
   assign data_out_ready_pin_oe_n = oe_n_reg;
   assign modulator_run = run_reg;
   assign modulator_start = start_reg;
   assign single_mode = single_reg;
   assign shutdown = shutdown_reg;

endmodule

// File: readout_chk.sv
`timescale 1ns/10ps
module readout_chk
   import adc_readout_pkg::*;
#(
   parameter int unsigned CONVERSION_CYCLES = 30
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cs_n_pin,
   input wire logic data_out_ready_pin_out,
   input wire logic data_out_ready_pin_oe_n,
   input wire logic modulator_run,
   input wire logic modulator_start,
   input wire logic single_mode,
   input wire logic shutdown
);
   logic [31:0] run_cnt_reg;
   logic [31:0] run_cnt_next;

   // Cycles with modulator_run high since the last conversion start
   assign run_cnt_next = modulator_start ? 32'h0000_0001 : run_cnt_reg + 32'h0000_0001;
   always_ff @(posedge clk) begin
      if (reset) begin
         run_cnt_reg <= 32'h0000_0000;
      end else if (modulator_run) begin
         run_cnt_reg <= run_cnt_next;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_oe_released: assert property (cs_n_pin [*5] |-> data_out_ready_pin_oe_n)
      else $error("pin driven with chip select high");
   a_oe_driven: assert property ((!cs_n_pin) [*5] |-> !data_out_ready_pin_oe_n)
      else $error("pin not driven with chip select low");
   a_powerup_wait: assert property ($fell(shutdown) |-> ##32 modulator_start)
      else $error("power-up delay wrong");
   a_start_runs: assert property (modulator_start |-> modulator_run)
      else $error("start without run");
   a_conv_length: assert property ($fell(modulator_run) |-> run_cnt_reg == CONVERSION_CYCLES)
      else $error("conversion length wrong");
   a_back_to_back: assert property (modulator_start && $past(modulator_run)
      |-> run_cnt_reg == CONVERSION_CYCLES)
      else $error("continuous restart spacing wrong");
   a_single_stops: assert property ($fell(modulator_run)
      |-> ($past(single_mode) || single_mode) ##1 (!modulator_run) [*8])
      else $error("single mode restarted");
   a_busy_level: assert property (modulator_run && single_mode && !data_out_ready_pin_oe_n
      |-> data_out_ready_pin_out)
      else $error("pin not busy during conversion");
   a_ready_shown: assert property ($fell(modulator_run) && !data_out_ready_pin_oe_n
      |-> ##[0:2] !data_out_ready_pin_out)
      else $error("ready not shown after conversion");

   cover property ($fell(modulator_run) && single_mode);
   cover property (modulator_start && $past(modulator_run));
   cover property ($fell(shutdown));
endmodule

bind adc_serial_readout_control readout_chk #(.CONVERSION_CYCLES(CONVERSION_CYCLES)) u_chk (
   .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin),
   .data_out_ready_pin_out(data_out_ready_pin_out),
   .data_out_ready_pin_oe_n(data_out_ready_pin_oe_n),
   .modulator_run(modulator_run), .modulator_start(modulator_start),
   .single_mode(single_mode), .shutdown(shutdown)
);

// File: host_model.sv
`timescale 1ns/10ps
module host_model (
   output logic sck,
   output logic comm_error,
   input wire logic pin
);
   initial begin
      sck = 1'b0; // Idle low outside frames
      comm_error = 1'b0;
   end

   // Ready bit then 24 bits, sampled on rising clock
   task automatic read_frame(output logic rdy, output logic [23:0] word);
      word = 24'h00_0000;
      #1.7;
      for (int i = 0; i < 25; i++) begin
         sck = 1'b1;
         if (i == 0) rdy = pin;
         else word = {word[22:0], pin};
         #3 sck = 1'b0;
         #3;
      end
      comm_error = word[23] & word[22]; // Both flags set is an error
   endtask
endmodule

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
   import adc_readout_pkg::*;
   localparam int unsigned CONV = 30;
   logic clk, reset, cs_n, sck, pin_out, oe_n, run, start, single, shut, last_pin, pin;
   logic comm_error;
   logic [FILTER_BITS-1:0] code;
   int bad_count, checks_done;

   adc_serial_readout_control #(.CONVERSION_CYCLES(CONV)) u_dut (
      .clk(clk), .reset(reset), .sck(sck), .cs_n_pin(cs_n), .filter_code(code),
      .data_out_ready_pin_out(pin_out), .data_out_ready_pin_oe_n(oe_n),
      .modulator_run(run), .modulator_start(start), .single_mode(single), .shutdown(shut)
   );
   host_model u_host (.sck(sck), .comm_error(comm_error), .pin(pin));

   // Released pin shows the inverse of its last level
   always @(*) begin
      if (!oe_n) last_pin = pin_out;
      pin = oe_n ? ~last_pin : pin_out;
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wait_for(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("wait bound", 24'(n < 200), 24'h00_0001);
   endtask

   task automatic single_conv(input logic [22:0] v, input logic [23:0] exp);
      logic rdy;
      logic [23:0] w;
      int n;
      code = v;
      cs_n = 1'b0;
      wait_for(shut, 1'b0, n);
      wait_for(start, 1'b1, n);
      check("powerup", 24'(n), 24'h00_0020);
      tick(3);
      cs_n = 1'b1;
      tick(6);
      cs_n = 1'b0;
      tick(8);
      check("busy", 24'(pin), 24'h00_0001);
      check("single", 24'(single), 24'h00_0001);
      wait_for(run, 1'b0, n);
      check("conv time", 24'(n + 17), 24'(CONV));
      tick(2);
      check("ready", 24'(pin), 24'h00_0000);
      u_host.read_frame(rdy, w);
      check("ready bit", 24'(rdy), 24'h00_0000);
      check("word", w, exp);
      check("flag error", 24'(comm_error), 24'(exp[23] & exp[22]));
      check("no restart", 24'(run), 24'h00_0000);
      check("after frame", 24'(pin), 24'h00_0001);
      tick(1);
      cs_n = 1'b1;
      tick(5);
      check("released", 24'(oe_n), 24'h00_0001);
      check("shutdown", 24'(shut), 24'h00_0001);
   endtask

   task automatic code_table;
      logic [22:0] vals [6] = '{23'h20_0001, 23'h20_0000, 23'h1f_ffff,
         23'h7f_ffff, 23'h60_0000, 23'h5f_ffff};
      logic [23:0] exps [6] = '{24'h60_0001, 24'h60_0000, 24'h1f_ffff,
         24'h3f_ffff, 24'h20_0000, 24'h9f_ffff};
      for (int i = 0; i < 6; i++) begin
         single_conv(vals[i], exps[i]);
      end
   endtask

   task automatic continuous_run;
      logic rdy;
      logic [23:0] w;
      int n;
      code = 23'h00_0123;
      cs_n = 1'b0;
      wait_for(shut, 1'b0, n);
      wait_for(start, 1'b1, n);
      wait_for(pin, 1'b0, n);
      code = 23'h00_0456;
      u_host.read_frame(rdy, w);
      check("held word", w, 24'h00_0123);
      check("continuous", 24'({run, single}), 24'h00_0002);
      wait_for(pin, 1'b0, n);
      u_host.read_frame(rdy, w);
      check("newest word", w, 24'h00_0456);
      tick(1);
      cs_n = 1'b1;
      wait_for(shut, 1'b1, n);
      check("stopped", 24'(run), 24'h00_0000);
   endtask

   task report_and_stop;
      $display("Checks done %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #40000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      cs_n = 1'b1;
      code = 23'h00_0000;
      last_pin = 1'b0;
      bad_count = 0;
      checks_done = 0;
      tick(12);
      reset = 1'b0;
      tick(2);
      check("reset oe", 24'(oe_n), 24'h00_0001);
      check("reset state", 24'({run, start, single, shut}), 24'h00_0001);
      code_table();
      continuous_run();
      report_and_stop();
   end
endmodule
